// ### dbm_pkg.sv
// Purpose: constants for the dma buffer manager status and statistics block
// Assumes: axi4-lite register access, 200 MHz mclk_i
// Notes:   register offsets are byte addresses
// Functional notes
// - count transmitted packets, 16 bits, wrapping
// - count packets dropped on busy bus
// - dropped packet still retires its descriptor
// - count consumed descriptors, 16 bits, wrapping
// - count consumed descriptor lists, 16 bits, wrapping
// - count loaded descriptors, 16 bits, wrapping
// - count loaded descriptor lists, 16 bits, wrapping
// - report engine state: align, header, fill
// - flag data waiting without any descriptor
// - flag video dropped while aligning
// - flag descriptor dropped while aligning
// - flag data fifo read while empty
// - flag data fifo write while full
// - flush buffered data after idle timeout
// - flag that a timeout flush happened
// - show two-position switch in bits 1..0
// - show boot bank switch in bits 7..4
// - show three straps in bits 14..12
// - one descriptor moves one contiguous chunk
// - control bit turns flush timer off
package dbm_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] BOARD_SWITCH_READBACK_OFS   = 8'h00;
  localparam logic [7:0] PACKET_SENT_DROP_COUNT_OFS  = 8'h04;
  localparam logic [7:0] CONSUMED_DESCRIPTOR_CNT_OFS = 8'h08;
  localparam logic [7:0] CONSUMED_LIST_COUNT_OFS     = 8'h0c;
  localparam logic [7:0] PACKET_ENGINE_STATUS_OFS    = 8'h10;
  localparam logic [7:0] LOADED_DESCRIPTOR_CNT_OFS   = 8'h14;
  localparam logic [7:0] LOADED_LIST_COUNT_OFS       = 8'h18;
  localparam logic [7:0] PACKET_ENGINE_CTRL_OFS      = 8'h1c;

  // ==========================================================
  // field positions
  localparam int SWITCH_LSB         = 0;
  localparam int BOOT_BANK_LSB      = 4;
  localparam int STRAP_LSB          = 12;
  localparam int DROP_CNT_LSB       = 16;
  localparam int NO_DESC_BIT        = 8;
  localparam int VIDEO_DROP_BIT     = 9;
  localparam int DESC_DROP_BIT      = 10;
  localparam int RD_EMPTY_BIT       = 13;
  localparam int WR_FULL_BIT        = 14;
  localparam int FORCED_FLUSH_BIT   = 16;
  localparam int FLUSH_TIMER_OFF_BIT = 30;

  // ==========================================================
  // reset values and responses
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ==========================================================
  // timing
  localparam int CLK_MHZ          = 200;
  localparam int FLUSH_TIMEOUT_NS = 1000;
  localparam int FLUSH_TIMEOUT_CYC = (FLUSH_TIMEOUT_NS * CLK_MHZ) / 1000;

  // engine state encoding as reported to software
  localparam logic [1:0] ST_ALIGN_CODE  = 2'b00;
  localparam logic [1:0] ST_HEADER_CODE = 2'b01;
  localparam logic [1:0] ST_FILL_CODE   = 2'b10;

  typedef enum logic [1:0] {align_state, header_build_state, payload_fill_state} dbm_state_e;

endpackage : dbm_pkg

// ### dbm_status.sv
// Purpose: packet engine, statistics counters and status readback over axi4-lite
// Assumes: all event inputs are one-cycle pulses synchronous to mclk_i
// Notes:   the data fifo itself lives outside; only its fill level is tracked here
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module dbm_status #(
  parameter int FIFO_DEPTH = 64,                                 // data fifo words
  parameter int PKT_WORDS  = 32,                                 // largest packet, words
  parameter int FLUSH_CYC  = dbm_pkg::FLUSH_TIMEOUT_CYC          // idle cycles to flush
) (
  input  wire logic        mclk_i,                // 200 MHz clock
  input  wire logic        rst_i,                 // sync reset, active high
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,        // write address
  input  wire logic        s_axi_awvalid_i,       // write address valid
  output logic             s_axi_awready_o,       // write address ready
  input  wire logic [31:0] s_axi_wdata_i,         // write data
  input  wire logic [3:0]  s_axi_wstrb_i,         // write strobes
  input  wire logic        s_axi_wvalid_i,        // write data valid
  output logic             s_axi_wready_o,        // write data ready
  output logic [1:0]       s_axi_bresp_o,         // write response
  output logic             s_axi_bvalid_o,        // write response valid
  input  wire logic        s_axi_bready_i,        // write response ready
  input  wire logic [7:0]  s_axi_araddr_i,        // read address
  input  wire logic        s_axi_arvalid_i,       // read address valid
  output logic             s_axi_arready_o,       // read address ready
  output logic [31:0]      s_axi_rdata_o,         // read data
  output logic [1:0]       s_axi_rresp_o,         // read response
  output logic             s_axi_rvalid_o,        // read data valid
  input  wire logic        s_axi_rready_i,        // read data ready
  // board inputs
  input  wire logic [1:0]  board_switch_value_i,  // general switch
  input  wire logic [3:0]  boot_bank_switch_i,    // boot bank switch
  input  wire logic [2:0]  board_strap_value_i,   // board straps
  // descriptor fetch side
  input  wire logic        desc_loaded_i,         // descriptor loaded into cache
  input  wire logic        list_loaded_i,         // descriptor list loaded
  input  wire logic        desc_valid_i,          // cached descriptor available (level)
  input  wire logic        desc_last_i,           // head descriptor ends its list (level)
  input  wire logic        desc_stale_i,          // head descriptor out of step (level)
  // video side
  input  wire logic        video_valid_i,         // video word offered
  input  wire logic        video_sof_i,           // word starts a frame
  input  wire logic        pcie_busy_i,           // pcie transmit busy
  // engine outputs
  output logic             fifo_wr_o,             // write word into data fifo
  output logic             fifo_rd_o,             // read word from data fifo
  output logic             pkt_xmit_o,            // packet handed to pcie
  output logic             desc_retire_o,         // head descriptor retired
  output dbm_pkg::dbm_state_e state_o             // engine state
);
  import dbm_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam int TW = $clog2(FLUSH_CYC + 1);
  localparam logic [LW-1:0] DEPTH_L = LW'(FIFO_DEPTH);
  localparam logic [LW-1:0] PKT_L   = LW'(PKT_WORDS);
  localparam logic [TW-1:0] FLUSH_L = TW'(FLUSH_CYC);

  // ==========================================================
  // registers
  dbm_state_e  state_r;
  logic [LW-1:0] level_r;
  logic [LW-1:0] remain_r;
  logic [TW-1:0] idle_r;
  logic        aligned_r;
  logic [15:0] sent_r, drop_r, used_desc_r, used_list_r, load_desc_r, load_list_r;
  logic        no_desc_r, video_drop_r, desc_drop_r, rd_empty_r, wr_full_r, flush_flag_r;
  logic        flush_timer_off_r;
  logic        aw_got_r, w_got_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // ==========================================================
  // decode helpers
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a <= PACKET_ENGINE_CTRL_OFS);
  endfunction : addr_mapped

  // ==========================================================
  // data path into the fifo and engine events
  logic wr_req, wr_ok, rd_req, rd_ok, flush_due, pkt_end;
  logic do_write, clr_full, clr_flush;

  // video is stored from the aligning start-of-frame word on; while aligning other words are discarded
  assign wr_req   = video_valid_i && (aligned_r || (video_sof_i && desc_valid_i
                    && !desc_stale_i));
  assign wr_ok    = wr_req && (level_r != DEPTH_L);
  assign rd_req   = (state_r == payload_fill_state) && (remain_r != '0);
  assign rd_ok    = rd_req && (level_r != '0);
  assign pkt_end  = (state_r == payload_fill_state) && (remain_r == LW'(1));
  assign flush_due = (idle_r == FLUSH_L) && !flush_timer_off_r;

  // the host moves its head one edge after a retire pulse, so in that
  // cycle the head it shows is spent: neither sent to nor retired again
  logic head_spent;
  assign head_spent = desc_retire_o;

  // ==========================================================
  // fifo level
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      level_r <= '0;
    else
      level_r <= level_r + LW'(wr_ok) - LW'(rd_ok);
  end

  // idle timer: runs in align_state while data sits in the fifo with nothing new arriving
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || wr_ok || level_r == '0 || state_r != align_state)
      idle_r <= '0;
    else if (idle_r != FLUSH_L)
      idle_r <= idle_r + TW'(1);
  end

  // ==========================================================
  // packet engine
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_r   <= align_state;
      aligned_r <= 1'b0;
      remain_r  <= '0;
    end
    else
    begin
      unique case (state_r)
        align_state:
        begin
          if (video_valid_i && video_sof_i && desc_valid_i && !desc_stale_i)
            aligned_r <= 1'b1;
          // full packet ready, or idle data forced out by the timer
          if (desc_valid_i && !desc_stale_i && !head_spent && level_r != '0
              && (level_r >= PKT_L || flush_due))
          begin
            state_r  <= header_build_state;
            remain_r <= (level_r >= PKT_L) ? PKT_L : level_r;
          end
        end
        header_build_state:
          state_r <= payload_fill_state;
        payload_fill_state:
        begin
          if (rd_req)
            remain_r <= remain_r - LW'(1);
          if (pkt_end)
            state_r <= align_state;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      fifo_wr_o     <= 1'b0;
      fifo_rd_o     <= 1'b0;
      pkt_xmit_o    <= 1'b0;
      desc_retire_o <= 1'b0;
      state_o       <= align_state;
    end
    else
    begin
      fifo_wr_o  <= wr_ok;
      fifo_rd_o  <= rd_ok;
      pkt_xmit_o <= pkt_end && !pcie_busy_i;
      // one descriptor per packet chunk, retired even when dropped
      desc_retire_o <= pkt_end || (state_r == align_state && desc_valid_i
                                   && desc_stale_i && !head_spent);
      state_o    <= state_r;
    end
  end

  // ==========================================================
  // statistics counters, all wrap at all ones
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sent_r      <= COUNT_RST;
      drop_r      <= COUNT_RST;
      used_desc_r <= COUNT_RST;
      used_list_r <= COUNT_RST;
      load_desc_r <= COUNT_RST;
      load_list_r <= COUNT_RST;
    end
    else
    begin
      if (pkt_end && !pcie_busy_i)
        sent_r <= sent_r + 16'h0001;
      if (pkt_end && pcie_busy_i)
        drop_r <= drop_r + 16'h0001;
      if (pkt_end)
        used_desc_r <= used_desc_r + 16'h0001;
      if (pkt_end && desc_last_i)
        used_list_r <= used_list_r + 16'h0001;
      if (desc_loaded_i)
        load_desc_r <= load_desc_r + 16'h0001;
      if (list_loaded_i)
        load_list_r <= load_list_r + 16'h0001;
    end
  end

  // ==========================================================
  // sticky status flags; a set in the clearing cycle wins
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      no_desc_r    <= 1'b0;
      video_drop_r <= 1'b0;
      desc_drop_r  <= 1'b0;
      rd_empty_r   <= 1'b0;
      wr_full_r    <= 1'b0;
      flush_flag_r <= 1'b0;
    end
    else
    begin
      if (level_r != '0 && !desc_valid_i)
        no_desc_r <= 1'b1;
      if (state_r == align_state && video_valid_i && !wr_req)
        video_drop_r <= 1'b1;
      if (state_r == align_state && desc_valid_i && desc_stale_i)
        desc_drop_r <= 1'b1;
      if (rd_req && level_r == '0)
        rd_empty_r <= 1'b1;
      if (wr_req && level_r == DEPTH_L)
        wr_full_r <= 1'b1;
      else if (clr_full)
        wr_full_r <= 1'b0;
      if (state_r == align_state && flush_due && desc_valid_i && !desc_stale_i
          && !head_spent && level_r != '0 && level_r < PKT_L)
        flush_flag_r <= 1'b1;
      else if (clr_flush)
        flush_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // axi4-lite write channel
  // address and data may land in either order; both held until the write fires
  assign do_write  = aw_got_r && w_got_r && !s_axi_bvalid_o;
  assign clr_full  = do_write && waddr_r == PACKET_ENGINE_STATUS_OFS
                     && wstrb_r[1] && wdata_r[WR_FULL_BIT];
  assign clr_flush = do_write && waddr_r == PACKET_ENGINE_STATUS_OFS
                     && wstrb_r[2] && wdata_r[FORCED_FLUSH_BIT];

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      aw_got_r        <= 1'b0;
      w_got_r         <= 1'b0;
      waddr_r         <= '0;
      wdata_r         <= '0;
      wstrb_r         <= '0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready_o <= s_axi_awvalid_i && !s_axi_awready_o && !aw_got_r;
      s_axi_wready_o  <= s_axi_wvalid_i && !s_axi_wready_o && !w_got_r;
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_got_r <= 1'b1;
        waddr_r  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_got_r       <= 1'b0;
        w_got_r        <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= addr_mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      flush_timer_off_r <= 1'b0;
    else if (do_write && waddr_r == PACKET_ENGINE_CTRL_OFS && wstrb_r[3])
      flush_timer_off_r <= wdata_r[FLUSH_TIMER_OFF_BIT];
  end

  // ==========================================================
  // axi4-lite read channel
  // data is taken at the address handshake; a later flag set shows next read
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    unique case (s_axi_araddr_i)
      BOARD_SWITCH_READBACK_OFS:
      begin
        rd_mux[SWITCH_LSB +: 2]    = board_switch_value_i;
        rd_mux[BOOT_BANK_LSB +: 4] = boot_bank_switch_i;
        rd_mux[STRAP_LSB +: 3]     = board_strap_value_i;
      end
      PACKET_SENT_DROP_COUNT_OFS:
        rd_mux = {drop_r, sent_r};
      CONSUMED_DESCRIPTOR_CNT_OFS:
        rd_mux[15:0] = used_desc_r;
      CONSUMED_LIST_COUNT_OFS:
        rd_mux[15:0] = used_list_r;
      PACKET_ENGINE_STATUS_OFS:
      begin
        unique case (state_r)
          align_state:        rd_mux[1:0] = ST_ALIGN_CODE;
          header_build_state: rd_mux[1:0] = ST_HEADER_CODE;
          payload_fill_state: rd_mux[1:0] = ST_FILL_CODE;
        endcase
        rd_mux[NO_DESC_BIT]      = no_desc_r;
        rd_mux[VIDEO_DROP_BIT]   = video_drop_r;
        rd_mux[DESC_DROP_BIT]    = desc_drop_r;
        rd_mux[RD_EMPTY_BIT]     = rd_empty_r;
        rd_mux[WR_FULL_BIT]      = wr_full_r;
        rd_mux[FORCED_FLUSH_BIT] = flush_flag_r;
        // bit 12 left at zero
      end
      LOADED_DESCRIPTOR_CNT_OFS:
        rd_mux[15:0] = load_desc_r;
      LOADED_LIST_COUNT_OFS:
        rd_mux[15:0] = load_list_r;
      PACKET_ENGINE_CTRL_OFS:
        rd_mux[FLUSH_TIMER_OFF_BIT] = flush_timer_off_r;
      default:
        rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o;
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_mux;
        s_axi_rresp_o  <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule : dbm_status

// ### dbm_status_asserts.sv
// Purpose: port-level checks on the status and statistics block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every dbm_status instance
`timescale 1ns/1ps
module dbm_status_asserts (
  input wire logic               mclk_i,          // clock
  input wire logic               rst_i,           // reset
  input wire logic               s_axi_arvalid_i, // read address valid
  input wire logic               s_axi_arready_o, // read address ready
  input wire logic               s_axi_rvalid_o,  // read data valid
  input wire logic               s_axi_awready_o, // write address ready
  input wire logic               s_axi_bvalid_o,  // write response valid
  input wire logic               pkt_xmit_o,      // packet sent
  input wire logic               desc_retire_o,   // descriptor retired
  input wire dbm_pkg::dbm_state_e state_o         // engine state
);
  import dbm_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // register bus
  chk_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data not one cycle after address");
  chk_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while data pending");
  chk_aw_pulse: assert property (s_axi_awready_o |=> !s_axi_awready_o)
    else $error("write address ready longer than one cycle");
  chk_wr_answer: assert property (s_axi_awready_o |-> ##[1:3] s_axi_bvalid_o)
    else $error("write response missing");
  // ==========================================================
  // packet engine
  chk_sent_retires: assert property (pkt_xmit_o |-> desc_retire_o)
    else $error("sent packet left its descriptor");
  chk_state_legal: assert property (state_o != 2'b11)
    else $error("unused engine state code");
  chk_header_fill: assert property (state_o == header_build_state |=>
    state_o == payload_fill_state)
    else $error("header not followed by fill");
  chk_send_after_fill: assert property (pkt_xmit_o |->
    (state_o == payload_fill_state || $past(state_o) == payload_fill_state))
    else $error("packet sent without fill");
  chk_xmit_pulse: assert property (pkt_xmit_o |=> !pkt_xmit_o)
    else $error("packet pulse too long");
  cov_sent: cover property (pkt_xmit_o);
  cov_dropped: cover property (desc_retire_o && !pkt_xmit_o);
  cov_header: cover property (state_o == header_build_state);
endmodule : dbm_status_asserts

bind dbm_status dbm_status_asserts u_chk (.*);

// ### dbm_host_model.sv
// Purpose: behavioural host side: descriptor cache feed and bus busy
// Assumes: fetch_i is a one-cycle request from the bench
// Notes:   head descriptor ends its list when it is the only one cached
`timescale 1ns/1ps
module dbm_host_model (
  input  wire logic mclk_i,        // clock
  input  wire logic rst_i,         // sync reset
  input  wire logic fetch_i,       // bench asks for one descriptor
  input  wire logic list_i,        // this fetch closes a list
  input  wire logic stale_i,       // mark head out of step
  input  wire logic busy_i,        // bench holds the bus busy
  input  wire logic retire_i,      // block retired the head
  output logic      desc_loaded_o, // descriptor landed
  output logic      list_loaded_o, // list landed
  output logic      desc_valid_o,  // cache not empty
  output logic      desc_last_o,   // head ends its list
  output logic      desc_stale_o,  // head out of step
  output logic      pcie_busy_o    // bus busy
);
  logic [7:0] cached_r;
  // ==========================================================
  // cache occupancy
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cached_r      <= 8'h00;
      desc_loaded_o <= 1'b0;
      list_loaded_o <= 1'b0;
    end
    else
    begin
      desc_loaded_o <= fetch_i;
      list_loaded_o <= fetch_i & list_i;
      cached_r <= cached_r + {7'h00, desc_loaded_o} - {7'h00, retire_i};
    end
  end
  assign desc_valid_o = (cached_r != 8'h00);
  assign desc_last_o  = (cached_r == 8'h01);
  assign desc_stale_o = stale_i & desc_valid_o;
  // busy is a plain level, so a drop can be forced on any packet
  assign pcie_busy_o  = busy_i;
endmodule : dbm_host_model

// ### dbm_status_tb_top.sv
// Purpose: self-checking bench for the status and statistics block
// Assumes: flush idle time shortened to 8 cycles, 32-word packets
// Notes:   ready inputs tied high, which the bus allows
`timescale 1ns/1ps
module dbm_status_tb_top;
  import dbm_pkg::*;
  localparam int PKT = 32;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  rresp, bresp, br;
  logic [1:0]  sw = 2'b10;
  logic [3:0]  boot = 4'ha;
  logic [2:0]  strap = 3'b101;
  logic        fetch = 1'b0, list = 1'b0, stale = 1'b0, busy = 1'b0;
  logic        vvalid = 1'b0, vsof = 1'b0, xm;
  logic        ld_d, ld_l, dvalid, dlast, dstale, pbusy, xmit, retire, fw, fr;
  dbm_state_e  st;
  int          fail_count = 0, samples_checked = 0;
  int          wr_n = 0, rd_n = 0, fill_n = 0;

  initial forever #2.5 mclk_i = ~mclk_i;

  always @(posedge mclk_i)
  begin
    wr_n   <= wr_n + int'(fw === 1'b1);
    rd_n   <= rd_n + int'(fr === 1'b1);
    fill_n <= fill_n + int'(st === payload_fill_state);
  end

  dbm_host_model host (.mclk_i(mclk_i), .rst_i(rst_i), .fetch_i(fetch), .list_i(list),
    .stale_i(stale), .busy_i(busy), .retire_i(retire), .desc_loaded_o(ld_d),
    .list_loaded_o(ld_l), .desc_valid_o(dvalid), .desc_last_o(dlast),
    .desc_stale_o(dstale), .pcie_busy_o(pbusy));
  dbm_status #(.FLUSH_CYC(8)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .board_switch_value_i(sw),
    .boot_bank_switch_i(boot), .board_strap_value_i(strap), .desc_loaded_i(ld_d),
    .list_loaded_i(ld_l), .desc_valid_i(dvalid), .desc_last_i(dlast),
    .desc_stale_i(dstale), .video_valid_i(vvalid), .video_sof_i(vsof),
    .pcie_busy_i(pbusy), .fifo_wr_o(fw), .fifo_rd_o(fr), .pkt_xmit_o(xmit),
    .desc_retire_o(retire), .state_o(st));

  // ==========================================================
  // shared tasks
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic hang(input string what);
    fail_count++;
    $display("wrong value at %0t: no answer on %s", $time, what);
    print_verdict();
  endtask : hang

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp32

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) hang("read");
    d = rdata;
    r = rresp;
  endtask : axi_rd

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) hang("write");
    br = bresp;
  endtask : axi_wr

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    cmp32({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
    cmp32(d, exp, "register value");
  endtask : chk_reg

  task automatic send_video(input int n);
    for (int i = 0; i < n; i++)
    begin
      vvalid <= 1'b1;
      vsof   <= (i == 0);
      @(posedge mclk_i);
    end
    vvalid <= 1'b0;
    vsof   <= 1'b0;
  endtask : send_video

  task automatic load(input int n, input logic lst);
    for (int i = 0; i < n; i++)
    begin
      fetch <= 1'b1;
      list  <= lst && (i == n - 1);
      @(posedge mclk_i);
      fetch <= 1'b0;
      list  <= 1'b0;
      @(posedge mclk_i);
    end
  endtask : load

  // retire pulse is the common end of sent, dropped and stale descriptors
  task automatic wait_retire;
    int n;
    for (n = 0; n < 80; n++)
    begin
      @(posedge mclk_i);
      if (retire === 1'b1) break;
    end
    if (n == 80) hang("retire");
    xm = xmit;
  endtask : wait_retire

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [7:0]  ofs [6] = '{8'h04, 8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (ofs[i]) chk_reg(ofs[i], 32'h0);
    chk_reg(PACKET_ENGINE_STATUS_OFS, 32'h0);
    chk_reg(BOARD_SWITCH_READBACK_OFS, 32'h0000_50a2);
    sw    <= 2'b01;
    boot  <= 4'h5;
    strap <= 3'b010;
    repeat (2) @(posedge mclk_i);
    chk_reg(BOARD_SWITCH_READBACK_OFS, 32'h0000_2051);
    axi_rd(8'h20, d, r);
    cmp32({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped response");
    cmp32(d, 32'h0, "unmapped data");
    axi_wr(PACKET_SENT_DROP_COUNT_OFS, 32'hffff_ffff);
    cmp32({30'h0, br}, {30'h0, RESP_OKAY}, "write response");
    chk_reg(PACKET_SENT_DROP_COUNT_OFS, 32'h0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_packets;
    send_video(1);
    chk_reg(PACKET_ENGINE_STATUS_OFS, 32'h0000_0200);
    load(2, 1'b1);
    chk_reg(LOADED_DESCRIPTOR_CNT_OFS, 32'h2);
    chk_reg(LOADED_LIST_COUNT_OFS, 32'h1);
    send_video(PKT);
    wait_retire();
    cmp32({31'h0, xm}, 32'h1, "packet sent");
    busy <= 1'b1;
    send_video(PKT);
    wait_retire();
    busy <= 1'b0;
    cmp32({31'h0, xm}, 32'h0, "packet dropped");
    chk_reg(PACKET_SENT_DROP_COUNT_OFS, 32'h0001_0001);
    chk_reg(CONSUMED_DESCRIPTOR_CNT_OFS, 32'h2);
    chk_reg(CONSUMED_LIST_COUNT_OFS, 32'h1);
    cmp32(32'(wr_n), 32'h40, "words stored");
    cmp32(32'(rd_n), 32'h40, "words read");
    cmp32(32'(fill_n), 32'h40, "fill cycles");
    $display("test packets done");
  endtask : t_packets

  task automatic t_flush;
    int seen;
    seen = 0;
    load(1, 1'b0);
    send_video(4);
    wait_retire();
    cmp32({31'h0, xm}, 32'h1, "flushed packet");
    chk_reg(PACKET_ENGINE_STATUS_OFS, 32'h0001_0200);
    axi_wr(PACKET_ENGINE_STATUS_OFS, 32'h0001_0000);
    chk_reg(PACKET_ENGINE_STATUS_OFS, 32'h0000_0200);
    axi_wr(PACKET_ENGINE_CTRL_OFS, 32'h4000_0000);
    chk_reg(PACKET_ENGINE_CTRL_OFS, 32'h4000_0000);
    load(1, 1'b0);
    send_video(4);
    repeat (40)
    begin
      @(posedge mclk_i);
      if (retire === 1'b1) seen++;
    end
    cmp32(32'(seen), 32'h0, "flush while timer off");
    $display("test flush done");
  endtask : t_flush

  task automatic t_stale;
    stale <= 1'b1;
    wait_retire();
    stale <= 1'b0;
    cmp32({31'h0, xm}, 32'h0, "stale descriptor sent");
    chk_reg(PACKET_ENGINE_STATUS_OFS, 32'h0000_0700);
    send_video(61);
    chk_reg(PACKET_ENGINE_STATUS_OFS, 32'h0000_4700);
    axi_wr(PACKET_ENGINE_STATUS_OFS, 32'h0000_4000);
    chk_reg(PACKET_ENGINE_STATUS_OFS, 32'h0000_0700);
    $display("test stale done");
  endtask : t_stale

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs();
    t_packets();
    t_flush();
    t_stale();
    print_verdict();
  end
endmodule : dbm_status_tb_top
